// [src/som_top.sv]
// Status output mapper: physical and virtual status outputs with an APB register file.
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "som_consts.svh"
module som_top #(
  parameter int unsigned VSO_CYC = `SOM_VSO_MS * (`SOM_CLK_HZ / 1000),
  parameter int unsigned TABLE_CYC = `SOM_TABLE_MS * (`SOM_CLK_HZ / 1000),
  parameter int unsigned FLASH_CYC = `SOM_FLASH_MS * (`SOM_CLK_HZ / 1000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire som_pkg::som_in_s in_state,
  input wire som_pkg::som_so_s so_state,
  input wire som_pkg::som_sys_s sys_state,
  input wire logic eval_done,
  input wire logic system_reset,
  output logic [7:0] status_out
);
  logic net_en;
  logic [15:0] group_mask;
  som_pkg::som_cfg_s cfg [`SOM_N_CFG];
  logic [`SOM_N_CFG-1:0] cond;
  logic [`SOM_N_VSO-1:0] live;
  logic [31:0] vso_value;
  logic [31:0] input_table;
  logic [15:0] armed;
  logic [15:0] bypassed;
  logic grp_valid;
  logic [3:0] grp_idx;
  logic flash;
  logic [31:0] flash_cnt;
  logic [31:0] vso_cnt;
  logic [31:0] table_cnt;
  logic sys_wait;
  logic [15:0] grp_off;
  logic [3:0] next_grp_idx;
  logic apb_access;
  logic apb_done;
  logic cfg_hit;
  logic [5:0] cfg_idx;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic rd_load;
  logic wr_ctrl;
  logic wr_group;
  logic wr_cfg;
  logic flash_tick;
  logic vso_tick;
  logic table_tick;

  // Bus decode: access phase, completion and per-register write strobes.
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;
  assign cfg_hit = (paddr >= `SOM_ADDR_CFG_BASE) && (paddr <= `SOM_ADDR_CFG_LAST)
                   && (paddr[1:0] == 2'h0);
  assign cfg_idx = 6'((paddr - `SOM_ADDR_CFG_BASE) >> 2);
  assign rd_load = apb_access & ~pready;
  assign wr_ctrl = apb_done & pwrite & (paddr == `SOM_ADDR_CTRL);
  assign wr_group = apb_done & pwrite & (paddr == `SOM_ADDR_GROUP_MASK);
  assign wr_cfg = apb_done & pwrite & cfg_hit;

  // One wait state: the answer is registered in the first access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= apb_access & ~pready;
    end
  end

  // Read multiplexer; an unmapped address answers with an error and zero data.
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    if (cfg_hit) begin
      next_prdata = {21'h00_0000, cfg[cfg_idx]};
    end else begin
      case (paddr)
        `SOM_ADDR_CTRL: next_prdata = {31'h0000_0000, net_en};
        `SOM_ADDR_GROUP_MASK: next_prdata = {16'h0000, group_mask};
        `SOM_ADDR_PHYS_STATUS: next_prdata = {24'h00_0000, status_out};
        `SOM_ADDR_VSO_STATUS: next_prdata = vso_value;
        `SOM_ADDR_GROUP_FIRST: next_prdata = {27'h000_0000, grp_valid, grp_idx};
        `SOM_ADDR_INPUT_TABLE: next_prdata = input_table;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // Read data is loaded in the first access cycle and stands with pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_load) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
    end
  end

  // The error flag stands only in the cycle that carries pready.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr <= 1'b0;
    end else begin
      pslverr <= rd_load & next_pslverr;
    end
  end

  // Register writes take effect at the completing edge of the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      net_en <= `SOM_CTRL_RESET;
    end else if (wr_ctrl) begin
      net_en <= pwdata[`SOM_CTRL_NET_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_mask <= `SOM_GROUP_MASK_RESET;
    end else if (wr_group) begin
      group_mask <= pwdata[15:0];
    end
  end

  // Each configuration entry is its own register, written only at its index.
  for (genvar k = 0; k < `SOM_N_CFG; k++) begin : g_cfg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cfg[k] <= `SOM_CFG_RESET;
      end else if (wr_cfg && cfg_idx == 6'(k)) begin
        cfg[k] <= pwdata[`SOM_CFG_WIDTH-1:0];
      end
    end
  end

  // Flash timer for the override indication, half period on, half off.
  assign flash_tick = (flash_cnt >= FLASH_CYC - 1);

  // The flash divider wraps once per half period.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cnt <= 32'h0000_0000;
    end else if (flash_tick) begin
      flash_cnt <= 32'h0000_0000;
    end else begin
      flash_cnt <= flash_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash <= 1'b0;
    end else if (flash_tick) begin
      flash <= ~flash;
    end
  end

  // Bypass arming: cleared at power-up, set once the input is seen open.
  for (genvar n = 0; n < `SOM_N_IN; n++) begin : g_bypass
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        armed[n] <= 1'b0;
      end else if (eval_done) begin
        if (!in_state.run[n]) begin
          armed[n] <= 1'b1;
        end else if (bypassed[n] && !in_state.bypass_req[n]) begin
          armed[n] <= 1'b0;
        end
      end
    end

    // A bypass request is honoured only for an armed or open input.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        bypassed[n] <= 1'b0;
      end else if (eval_done) begin
        bypassed[n] <= in_state.bypass_req[n] & (armed[n] | ~in_state.run[n]);
      end
    end
  end

  // First-off group: lowest index among the group inputs that are off wins.
  assign grp_off = group_mask & ~in_state.run;
  always_comb begin
    next_grp_idx = 4'h0;
    for (int i = `SOM_N_IN - 1; i >= 0; i--) begin
      if (grp_off[i]) begin
        next_grp_idx = 4'(i);
      end
    end
  end

  // The group latches its first-off input and holds it until rearmed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_valid <= 1'b0;
    end else if (eval_done) begin
      if (!grp_valid && grp_off != 16'h0000) begin
        grp_valid <= 1'b1;
      end else if (grp_valid && system_reset && grp_off == 16'h0000) begin
        grp_valid <= 1'b0;
      end
    end
  end

  // The index is captured only on the evaluation that latches the group.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      grp_idx <= 4'h0;
    end else if (eval_done && !grp_valid && grp_off != 16'h0000) begin
      grp_idx <= next_grp_idx;
    end
  end

  // Mode exits and group rearm are deliberately absent from this term.
  assign sys_wait = (sys_state.sys_fault && so_state.phys == 4'h0)
                    || sys_state.contactor_feedback_check_fault
                    || sys_state.valve_feedback_check_fault
                    || sys_state.so_fault
                    || sys_state.mute_lamp_fault
                    || sys_state.two_hand_control_input_fault
                    || sys_state.powerup_manual_reset;

  // Evaluates one entry's tracked condition and applies its polarity.
  function automatic logic eval_func(som_pkg::som_cfg_s c);
    logic r;
    logic [3:0] ix;
    logic [1:0] ox;
    r = 1'b0;
    ix = c.sel[3:0];
    ox = c.sel[1:0];
    case (c.func)
      `SOM_FUNC_TRACK_IN: r = in_state.run[ix];
      `SOM_FUNC_TRACK_OUT: r = c.logical ? so_state.logical[ox] : so_state.phys[ox];
      `SOM_FUNC_LOCKOUT: r = sys_state.lockout;
      `SOM_FUNC_IO_FAULT: r = sys_state.io_fault;
      `SOM_FUNC_SYS_WAIT: r = sys_wait;
      `SOM_FUNC_OUT_WAIT: r = so_state.ready_wait[ox];
      `SOM_FUNC_MUTE: r = in_state.mute_active[ix] | bypassed[ix]
                          | (in_state.override_ok[ix] & flash);
      `SOM_FUNC_FIRST_OFF: r = grp_valid && grp_idx == ix;
      `SOM_FUNC_BYPASS: r = bypassed[ix];
      `SOM_FUNC_IN_FAULT: r = in_state.fault[ix];
      `SOM_FUNC_CANCEL_OK: r = so_state.cancel_ok[ox];
      default: r = 1'b0;
    endcase
    return r ^ c.pol;
  endfunction

  // A process per entry, so that every state the function reads wakes it.
  for (genvar g = 0; g < `SOM_N_CFG; g++) begin : g_eval
    always_comb begin
      cond[g] = eval_func(cfg[g]);
    end
  end

  // Outputs hold their reset level until the first completed evaluation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_out <= 8'h00;
    end else if (eval_done) begin
      status_out <= cond[`SOM_N_STAT-1:0];
    end
  end

  // Virtual entries are latched with the same evaluation as the physical ones.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      live <= 32'h0000_0000;
    end else if (eval_done) begin
      live <= cond[`SOM_N_CFG-1:`SOM_N_STAT];
    end
  end

  // Network copies refresh on fixed ticks; disabled network shows nothing.
  assign vso_tick = net_en && (vso_cnt >= VSO_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vso_cnt <= 32'h0000_0000;
    end else if (!net_en || vso_tick) begin
      vso_cnt <= 32'h0000_0000;
    end else begin
      vso_cnt <= vso_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vso_value <= 32'h0000_0000;
    end else if (!net_en) begin
      vso_value <= 32'h0000_0000;
    end else if (vso_tick) begin
      vso_value <= live;
    end
  end

  // The input table refreshes on its own slower tick.
  assign table_tick = (table_cnt >= TABLE_CYC - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      table_cnt <= 32'h0000_0000;
    end else if (table_tick) begin
      table_cnt <= 32'h0000_0000;
    end else begin
      table_cnt <= table_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_table <= 32'h0000_0000;
    end else if (table_tick) begin
      input_table <= {bypassed, in_state.run};
    end
  end
endmodule

// [src/som_consts.svh]
// Constants for the status output mapper: offsets, fields, resets and timing.
`ifndef SOM_CONSTS_SVH
`define SOM_CONSTS_SVH
`define SOM_N_IN 16
`define SOM_N_SO 4
`define SOM_N_STAT 8
`define SOM_N_VSO 32
`define SOM_N_CFG 40
`define SOM_CLK_HZ 100000000
`define SOM_VSO_MS 100
`define SOM_TABLE_MS 1000
`define SOM_FLASH_MS 250
`define SOM_ADDR_CTRL 12'h000
`define SOM_ADDR_GROUP_MASK 12'h004
`define SOM_ADDR_PHYS_STATUS 12'h008
`define SOM_ADDR_VSO_STATUS 12'h00C
`define SOM_ADDR_GROUP_FIRST 12'h010
`define SOM_ADDR_INPUT_TABLE 12'h014
`define SOM_ADDR_CFG_BASE 12'h040
`define SOM_ADDR_CFG_LAST 12'h0DC
`define SOM_CTRL_NET_EN_BIT 0
`define SOM_CFG_WIDTH 11
`define SOM_CTRL_RESET 1'h0
`define SOM_GROUP_MASK_RESET 16'h0000
`define SOM_CFG_RESET 11'h000
`define SOM_FUNC_TRACK_IN 4'h0
`define SOM_FUNC_TRACK_OUT 4'h1
`define SOM_FUNC_LOCKOUT 4'h2
`define SOM_FUNC_IO_FAULT 4'h3
`define SOM_FUNC_SYS_WAIT 4'h4
`define SOM_FUNC_OUT_WAIT 4'h5
`define SOM_FUNC_MUTE 4'h6
`define SOM_FUNC_FIRST_OFF 4'h7
`define SOM_FUNC_BYPASS 4'h8
`define SOM_FUNC_IN_FAULT 4'h9
`define SOM_FUNC_CANCEL_OK 4'hA
`endif

// [src/som_pkg.sv]
// Types shared by the status output mapper.
package som_pkg;
  typedef logic [3:0] som_func_t;
  typedef struct packed {
    logic pol;
    logic logical;
    som_func_t func;
    logic [4:0] sel;
  } som_cfg_s;
  typedef struct packed {
    logic [15:0] run;
    logic [15:0] fault;
    logic [15:0] bypass_req;
    logic [15:0] mute_active;
    logic [15:0] override_ok;
  } som_in_s;
  typedef struct packed {
    logic [3:0] phys;
    logic [3:0] logical;
    logic [3:0] ready_wait;
    logic [3:0] cancel_ok;
  } som_so_s;
  typedef struct packed {
    logic lockout;
    logic io_fault;
    logic sys_fault;
    logic contactor_feedback_check_fault;
    logic valve_feedback_check_fault;
    logic so_fault;
    logic mute_lamp_fault;
    logic two_hand_control_input_fault;
    logic powerup_manual_reset;
  } som_sys_s;
endpackage

// [verif/som_checker.sv]
// Port assertions for the status output mapper.
`timescale 1ns/1ns
module som_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic eval_done,
  input wire logic [7:0] status_out
);
  logic seen_eval;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_eval <= 1'b0;
    end else if (eval_done) begin
      seen_eval <= 1'b1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_idle_hold: assert property (!eval_done |=> $stable(status_out))
    else $error("status output moved without an evaluation");
  chk_reset_level: assert property (!seen_eval |-> status_out == 8'h00)
    else $error("status output active before first evaluation");
  chk_wait_state: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("bus answer not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("bus ready longer than one cycle");
  chk_ready_qual: assert property (pready |-> psel && penable)
    else $error("bus ready outside an access");
  chk_err_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  chk_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data nonzero on a write");
  chk_ctrl_ok: assert property (pready && paddr == 12'h000 |-> !pslverr)
    else $error("control register refused");
  chk_unmap_err: assert property (pready && paddr == 12'h0E0 |-> pslverr)
    else $error("unmapped address accepted");
endmodule
bind som_top som_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .eval_done(eval_done), .status_out(status_out));

// [verif/som_far_model.sv]
// Machine side model that presents input states with each finished evaluation.
`timescale 1ns/1ns
module som_far_model #(
  parameter int GAP = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire som_pkg::som_in_s c_in,
  input wire som_pkg::som_so_s c_so,
  input wire som_pkg::som_sys_s c_sys,
  input wire logic c_rst,
  output som_pkg::som_in_s in_state,
  output som_pkg::som_so_s so_state,
  output som_pkg::som_sys_s sys_state,
  output logic eval_done,
  output logic system_reset
);
  int cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      eval_done <= 1'b0;
      in_state <= '0;
      so_state <= '0;
      sys_state <= '0;
      system_reset <= 1'b0;
    end else if (cnt == GAP) begin
      cnt <= 0;
      eval_done <= 1'b1;
      in_state <= c_in;
      so_state <= c_so;
      sys_state <= c_sys;
      system_reset <= c_rst;
    end else begin
      cnt <= cnt + 1;
      eval_done <= 1'b0;
    end
  end
endmodule

// [verif/som_top_tb.sv]
// Self-checking testbench for the status output mapper.
`timescale 1ns/1ns
module som_top_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic eval_done, system_reset, c_rst;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] status_out;
  logic [1:0] seen;
  som_pkg::som_in_s in_state, c_in;
  som_pkg::som_so_s so_state, c_so;
  som_pkg::som_sys_s sys_state, c_sys;
  int errors, checks;
  som_top #(.VSO_CYC(8), .TABLE_CYC(16), .FLASH_CYC(4)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_state(in_state), .so_state(so_state), .sys_state(sys_state),
    .eval_done(eval_done), .system_reset(system_reset), .status_out(status_out));
  som_far_model u_far (.pclk(pclk), .presetn(presetn), .c_in(c_in), .c_so(c_so),
    .c_sys(c_sys), .c_rst(c_rst), .in_state(in_state), .so_state(so_state),
    .sys_state(sys_state), .eval_done(eval_done), .system_reset(system_reset));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic ev;
    int c;
    c = 0;
    for (int i = 0; i < 60 && c < 3; i++) begin
      @(posedge pclk);
      if (eval_done === 1'b1) c++;
    end
    @(posedge pclk);
    #1;
    if (c < 3) begin
      errors++;
      tally_and_finish();
    end
  endtask
  task automatic drv(input logic [10:0] m);
    c_in = '0;
    c_so = '0;
    c_sys = '0;
    c_in.run = {16{m[0]}};
    c_so.phys = {4{m[1]}};
    c_sys.lockout = m[2];
    c_sys.io_fault = m[3];
    c_sys.contactor_feedback_check_fault = m[4];
    c_so.ready_wait = {4{m[5]}};
    c_in.mute_active = {16{m[6]}};
    c_in.fault = {16{m[9]}};
    c_so.cancel_ok = {4{m[10]}};
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    c_rst = 1'b0;
    errors = 0;
    checks = 0;
    drv(11'h001);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h0E0, 32'h0);
    cb(er, 1'b1);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h040, 32'h100);
    c_in.run = '1;
    c_in.bypass_req = '1;
    ev();
    cb(status_out[0], 1'b0);
    c_in.run = '0;
    ev();
    cb(status_out[0], 1'b1);
    c_in.bypass_req = '0;
    ev();
    cb(status_out[0], 1'b0);
    for (int f = 0; f < 11; f++) begin
      if (f == 7 || f == 8) continue;
      for (int p = 0; p < 2; p++) begin
        apb(1'b1, 12'h040, {21'h0, p[0], 1'b0, f[3:0], 5'h00});
        drv(11'(1 << f));
        ev();
        cb(status_out[0], ~p[0]);
        drv(11'h000);
        ev();
        cb(status_out[0], p[0]);
      end
    end
    apb(1'b1, 12'h040, 32'h220);
    drv(11'h002);
    ev();
    cb(status_out[0], 1'b0);
    c_so.logical = 4'hF;
    ev();
    cb(status_out[0], 1'b1);
    apb(1'b1, 12'h040, 32'h080);
    for (int j = 0; j < 5; j++) begin
      drv(11'h000);
      c_sys = 9'(1 << j);
      ev();
      cb(status_out[0], 1'b1);
    end
    c_sys = 9'h040;
    ev();
    cb(status_out[0], 1'b1);
    c_so.phys = 4'hF;
    ev();
    cb(status_out[0], 1'b0);
    apb(1'b1, 12'h040, 32'h0C0);
    drv(11'h000);
    c_in.override_ok = '1;
    ev();
    seen = 2'b00;
    for (int i = 0; i < 24; i++) begin
      @(posedge pclk);
      seen[status_out[0]] = 1'b1;
    end
    chk({30'h0, seen}, 32'h3);
    apb(1'b1, 12'h004, 32'h3);
    apb(1'b1, 12'h040, 32'h0E0);
    apb(1'b1, 12'h044, 32'h0E1);
    apb(1'b1, 12'h048, 32'h080);
    drv(11'h001);
    c_rst = 1'b1;
    ev();
    c_rst = 1'b0;
    c_in.run[1] = 1'b0;
    ev();
    c_in.run[0] = 1'b0;
    ev();
    chk({29'h0, status_out[2:0]}, 32'h2);
    c_in.run = '1;
    ev();
    chk({29'h0, status_out[2:0]}, 32'h2);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h11);
    c_rst = 1'b1;
    ev();
    c_rst = 1'b0;
    chk({29'h0, status_out[2:0]}, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b1, 12'h060, 32'h400);
    ev();
    ev();
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'hFFFFFFFE);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000FFFF);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule
